// >>> logic/dee_pkg.sv
package dee_pkg;
	// link request kinds
	typedef enum logic [2:0] {
		REQ_KEY_WR = 3'b000,
		REQ_CTL_WR = 3'b001,
		REQ_CTL_RD = 3'b010,
		REQ_TBL_WR_LO = 3'b011,
		REQ_TBL_RD_LO = 3'b100,
		REQ_TBL_RD_HI = 3'b101,
		REQ_PSV_RD = 3'b110,
		REQ_KEY_RD = 3'b111
	} dee_req_e;

	typedef enum logic [1:0] {
		UNL_IDLE = 2'b00,
		UNL_GOT1 = 2'b01,
		UNL_OPEN = 2'b10
	} dee_unl_e;

	typedef enum logic [1:0] {
		OP_IDLE = 2'b00,
		OP_ERASE = 2'b01,
		OP_PROG = 2'b10
	} dee_op_e;

	// unlock keys
	localparam logic [15:0] KEY_FIRST = 16'h0055;
	localparam logic [15:0] KEY_SECOND = 16'h00AA;

	// nonvolatile_op_control fields
	localparam int CTL_START = 15;
	localparam int CTL_OP_WRITE_ENABLE = 14;
	localparam int CTL_ERR = 13;
	localparam int CTL_SKIP = 12;
	localparam int CTL_ERASE = 6;
	localparam logic [15:0] CTL_WMASK = 16'h707F;
	localparam logic [15:0] CTL_RESET = 16'h0000;

	// op_command_field codes
	localparam logic [5:0] CMD_ERASE8 = 6'h1A;
	localparam logic [5:0] CMD_ERASE4 = 6'h19;
	localparam logic [5:0] CMD_ERASE1 = 6'h18;
	localparam logic [3:0] CMD_BULK_HI = 4'h4;
	localparam logic [3:0] CMD_WORD_HI = 4'h1;

	localparam logic [15:0] ERASED_WORD = 16'hFFFF;
	localparam int ARRAY_DEPTH = 256;
	localparam int TMR_W = 12;
	localparam logic [TMR_W-1:0] ERASE_CYCLES = 12'h0FA0;
	localparam logic [TMR_W-1:0] PROG_CYCLES = 12'h07D0;

	// controller register offsets
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_WDATA = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_RDATA = 8'h10;
	localparam int STS_PEND = 0;
	localparam int STS_IRQ = 1;
	localparam int STS_RDV = 2;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : dee_pkg

// >>> logic/dee_link_if.sv
`timescale 1ns/100ps
interface dee_link_if;
	logic req_valid;
	dee_pkg::dee_req_e req_kind;
	logic [23:0] req_addr;
	logic [15:0] req_wdata;
	logic rsp_valid;
	logic [15:0] rsp_data;
	logic done_flag;

	modport dev (
		input req_valid,
		input req_kind,
		input req_addr,
		input req_wdata,
		output rsp_valid,
		output rsp_data,
		output done_flag
	);
	modport cpu (
		output req_valid,
		output req_kind,
		output req_addr,
		output req_wdata,
		input rsp_valid,
		input rsp_data,
		input done_flag
	);
endinterface : dee_link_if

// >>> logic/dee_op_timer.sv
`timescale 1ns/100ps
module dee_op_timer #(
	parameter int W = dee_pkg::TMR_W
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic load_i,
	input wire logic [W-1:0] count_i,
	input wire logic abort_i,
	output logic busy_o,
	output logic done_o
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic busy;
		logic done;
	} dee_tmr_s;

	dee_tmr_s r_reg;
	dee_tmr_s r_next;

	always_comb begin
		r_next = r_reg;
		r_next.done = 1'b0;
		if (abort_i) begin
			r_next.busy = 1'b0;
		end else if (load_i) begin
			r_next.busy = 1'b1;
			r_next.cnt = count_i;
		end else if (r_reg.busy) begin
			if (r_reg.cnt <= W'(1)) begin
				r_next.busy = 1'b0;
				r_next.done = 1'b1;
			end else begin
				r_next.cnt = r_reg.cnt - W'(1);
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign busy_o = r_reg.busy;
	assign done_o = r_reg.done;
endmodule : dee_op_timer

// >>> logic/dee_device.sv
// Operation
// - keys 55h then AAh, strict order
// - control write window: one following request
// - key register reads back zero
// - error set on reset abort, cleared otherwise
// - auto-erase unless skip bit set
// - erase-select picks erase or write
// - command codes pick 8, 4, 1 words
// - 0100xx erases whole array
// - 0001xx programs one word from latch
// - capture table-write address, 8+16 bits
// - low address bit always zero
// - high holder top bit always zero
// - 16-bit array, low-word reads only
// - software avoids reads while busy
// - completion raises done flag
// - bulk erase ignores captured address
// - software erases first when skipping
// - latch loaded by low table write
// - visibility-window reads return array data
// - software masks interrupts during unlock
// - requests never stalled during operations
`timescale 1ns/100ps
module dee_device #(
	parameter int DEPTH = dee_pkg::ARRAY_DEPTH,
	parameter logic [dee_pkg::TMR_W-1:0] ERASE_CYC = dee_pkg::ERASE_CYCLES,
	parameter logic [dee_pkg::TMR_W-1:0] PROG_CYC = dee_pkg::PROG_CYCLES
) (
	input wire logic CLK_SYS_I,
	input wire logic NRST_I,
	dee_link_if.dev LINK,
	input wire logic RESET_ABORT_I,
	output logic BUSY_O
);
	localparam int IW = $clog2(DEPTH);

	typedef struct packed {
		dee_pkg::dee_unl_e unl;
		dee_pkg::dee_op_e op;
		logic [15:0] ctl;
		logic [7:0] addr_high_capture;
		logic [15:0] addr_low_capture;
		logic [15:0] latch;
		logic [IW-1:0] op_idx;
		logic prog_pend;
		logic rsp_valid;
		logic [15:0] rsp_data;
		logic done;
		logic [1:0] abort_sync;
		logic [DEPTH-1:0][15:0] mem;
	} dee_dev_s;

	dee_dev_s r_reg;
	dee_dev_s r_next;
	logic tmr_load;
	logic [dee_pkg::TMR_W-1:0] tmr_count;
	logic tmr_abort;
	logic tmr_busy;
	logic tmr_done;

	dee_op_timer #(
		.W(dee_pkg::TMR_W)
	) u_timer (
		.clk_i(CLK_SYS_I),
		.nrst_i(NRST_I),
		.load_i(tmr_load),
		.count_i(tmr_count),
		.abort_i(tmr_abort),
		.busy_o(tmr_busy),
		.done_o(tmr_done)
	);

	// index bits an erase of this size ignores
	function automatic int erase_shift(input logic erase_sel, input logic [5:0] cmd);
		int sh;
		sh = 0;
		if (erase_sel && cmd == dee_pkg::CMD_ERASE8) begin
			sh = 3;
		end else if (erase_sel && cmd == dee_pkg::CMD_ERASE4) begin
			sh = 2;
		end else if (erase_sel && cmd[5:2] == dee_pkg::CMD_BULK_HI) begin
			sh = IW;
		end
		return sh;
	endfunction : erase_shift

	always_comb begin
		logic [15:0] wd;
		logic [IW-1:0] rd_idx;
		logic [IW-1:0] ii;
		logic erase_ok;
		logic write_ok;
		int sh;
		wd = LINK.req_wdata;
		rd_idx = LINK.req_addr[IW:1];
		ii = '0;
		erase_ok = 1'b0;
		write_ok = 1'b0;
		sh = 0;
		r_next = r_reg;
		r_next.rsp_valid = 1'b0;
		r_next.done = 1'b0;
		r_next.abort_sync = {r_reg.abort_sync[0], RESET_ABORT_I};
		tmr_load = 1'b0;
		tmr_count = '0;
		tmr_abort = 1'b0;

		// requests are always taken, busy or not
		if (LINK.req_valid) begin
			r_next.unl = dee_pkg::UNL_IDLE;
			case (LINK.req_kind)
				dee_pkg::REQ_KEY_WR: begin
					if (r_reg.unl == dee_pkg::UNL_GOT1 && wd == dee_pkg::KEY_SECOND) begin
						r_next.unl = dee_pkg::UNL_OPEN;
					end else if (wd == dee_pkg::KEY_FIRST) begin
						r_next.unl = dee_pkg::UNL_GOT1;
					end
				end
				dee_pkg::REQ_KEY_RD: begin
					r_next.rsp_valid = 1'b1;
					r_next.rsp_data = '0;
				end
				dee_pkg::REQ_CTL_WR: begin
					if (r_reg.op == dee_pkg::OP_IDLE) begin
						// start bit is not in the write mask
						r_next.ctl = (r_reg.ctl & ~dee_pkg::CTL_WMASK) | (wd & dee_pkg::CTL_WMASK);
						erase_ok = wd[dee_pkg::CTL_ERASE] && (wd[5:0] == dee_pkg::CMD_ERASE8
							|| wd[5:0] == dee_pkg::CMD_ERASE4 || wd[5:0] == dee_pkg::CMD_ERASE1
							|| wd[5:2] == dee_pkg::CMD_BULK_HI);
						write_ok = !wd[dee_pkg::CTL_ERASE]
							&& wd[5:2] == dee_pkg::CMD_WORD_HI;
						// start only in the unlock window with write enable
						if (wd[dee_pkg::CTL_START] && r_reg.unl == dee_pkg::UNL_OPEN
							&& wd[dee_pkg::CTL_OP_WRITE_ENABLE] && (erase_ok || write_ok)) begin
							r_next.ctl[dee_pkg::CTL_START] = 1'b1;
							r_next.op_idx = r_reg.addr_low_capture[IW:1];
							tmr_load = 1'b1;
							if (write_ok && wd[dee_pkg::CTL_SKIP]) begin
								r_next.op = dee_pkg::OP_PROG;
								r_next.prog_pend = 1'b0;
								tmr_count = PROG_CYC;
							end else begin
								r_next.op = dee_pkg::OP_ERASE;
								r_next.prog_pend = write_ok;
								tmr_count = ERASE_CYC;
							end
						end
					end
				end
				dee_pkg::REQ_CTL_RD: begin
					r_next.rsp_valid = 1'b1;
					r_next.rsp_data = r_reg.ctl;
				end
				dee_pkg::REQ_TBL_WR_LO: begin
					r_next.addr_high_capture = {1'b0, LINK.req_addr[22:16]};
					r_next.addr_low_capture = {LINK.req_addr[15:1], 1'b0};
					r_next.latch = wd;
				end
				dee_pkg::REQ_TBL_RD_LO, dee_pkg::REQ_PSV_RD: begin
					r_next.rsp_valid = 1'b1;
					r_next.rsp_data = r_reg.mem[rd_idx];
				end
				dee_pkg::REQ_TBL_RD_HI: begin
					r_next.rsp_valid = 1'b1;
					r_next.rsp_data = '0;
				end
				default: begin
					r_next.rsp_valid = 1'b0;
				end
			endcase
		end

		if (r_reg.abort_sync[1] && r_reg.op != dee_pkg::OP_IDLE) begin
			// pin or watchdog reset cut the cycle short
			tmr_abort = 1'b1;
			r_next.op = dee_pkg::OP_IDLE;
			r_next.prog_pend = 1'b0;
			r_next.ctl[dee_pkg::CTL_START] = 1'b0;
			r_next.ctl[dee_pkg::CTL_OP_WRITE_ENABLE] = 1'b0;
			r_next.ctl[dee_pkg::CTL_ERR] = 1'b1;
		end else if (tmr_done) begin
			case (r_reg.op)
				dee_pkg::OP_ERASE: begin
					sh = erase_shift(r_reg.ctl[dee_pkg::CTL_ERASE], r_reg.ctl[5:0]);
					for (int i = 0; i < DEPTH; i++) begin
						ii = IW'(i);
						// bulk shifts out every index bit
						if ((ii >> sh) == (r_reg.op_idx >> sh)) begin
							r_next.mem[i] = dee_pkg::ERASED_WORD;
						end
					end
					if (r_reg.prog_pend) begin
						r_next.op = dee_pkg::OP_PROG;
						r_next.prog_pend = 1'b0;
						tmr_load = 1'b1;
						tmr_count = PROG_CYC;
					end
				end
				dee_pkg::OP_PROG: begin
					r_next.mem[r_reg.op_idx] = r_reg.latch;
				end
				default: begin
					r_next.op = dee_pkg::OP_IDLE;
				end
			endcase
			if (!(r_reg.op == dee_pkg::OP_ERASE && r_reg.prog_pend)) begin
				r_next.op = dee_pkg::OP_IDLE;
				r_next.ctl[dee_pkg::CTL_START] = 1'b0;
				r_next.ctl[dee_pkg::CTL_OP_WRITE_ENABLE] = 1'b0;
				r_next.ctl[dee_pkg::CTL_ERR] = 1'b0;
				r_next.done = 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign LINK.rsp_valid = r_reg.rsp_valid;
	assign LINK.rsp_data = r_reg.rsp_data;
	assign LINK.done_flag = r_reg.done;
	assign BUSY_O = r_reg.ctl[dee_pkg::CTL_START];
endmodule : dee_device

// >>> logic/dee_cpu_ctrl.sv
`timescale 1ns/100ps
module dee_cpu_ctrl #(
	parameter int ADDR_W = 8
) (
	input wire logic CLK_SYS_I,
	input wire logic NRST_I,
	dee_link_if.cpu LINK,
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I
);
	typedef struct packed {
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic req_pend;
		dee_pkg::dee_req_e req_kind;
		logic [23:0] req_addr;
		logic [15:0] req_wdata;
		logic [15:0] rd_data;
		logic rd_valid;
		logic irq;
	} dee_cpu_s;

	dee_cpu_s r_reg;
	dee_cpu_s r_next;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	always_comb begin
		logic [7:0] ra;
		logic [31:0] cur;
		ra = 8'(S_AXI_ARADDR_I);
		cur = '0;
		r_next = r_reg;
		r_next.req_pend = 1'b0;
		if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
			r_next.aw_got = 1'b1;
			r_next.aw_addr = 8'(S_AXI_AWADDR_I);
		end
		if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
			r_next.w_got = 1'b1;
			r_next.w_data = S_AXI_WDATA_I;
			r_next.w_strb = S_AXI_WSTRB_I;
		end
		if (r_reg.bvalid && S_AXI_BREADY_I) begin
			r_next.bvalid = 1'b0;
		end
		if (r_reg.aw_got && r_reg.w_got) begin
			r_next.aw_got = 1'b0;
			r_next.w_got = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp = dee_pkg::RESP_OKAY;
			case (r_reg.aw_addr)
				dee_pkg::OFS_CMD: begin
					if (r_reg.w_strb[0]) begin
						r_next.req_pend = 1'b1;
						r_next.req_kind = dee_pkg::dee_req_e'(r_reg.w_data[2:0]);
					end
				end
				dee_pkg::OFS_ADDR: begin
					cur = merge({8'h00, r_reg.req_addr}, r_reg.w_data, r_reg.w_strb);
					r_next.req_addr = cur[23:0];
				end
				dee_pkg::OFS_WDATA: begin
					cur = merge({16'h0000, r_reg.req_wdata}, r_reg.w_data, r_reg.w_strb);
					r_next.req_wdata = cur[15:0];
				end
				dee_pkg::OFS_STATUS: begin
					if (r_reg.w_strb[0] && r_reg.w_data[dee_pkg::STS_IRQ]) begin
						r_next.irq = 1'b0;
					end
					if (r_reg.w_strb[0] && r_reg.w_data[dee_pkg::STS_RDV]) begin
						r_next.rd_valid = 1'b0;
					end
				end
				dee_pkg::OFS_RDATA: begin
					r_next.bresp = dee_pkg::RESP_OKAY;
				end
				default: begin
					r_next.bresp = dee_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (r_reg.rvalid && S_AXI_RREADY_I) begin
			r_next.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
			r_next.rvalid = 1'b1;
			r_next.rresp = dee_pkg::RESP_OKAY;
			r_next.rdata = '0;
			case (ra)
				dee_pkg::OFS_CMD: r_next.rdata = {29'h0000_0000, r_reg.req_kind};
				dee_pkg::OFS_ADDR: r_next.rdata = {8'h00, r_reg.req_addr};
				dee_pkg::OFS_WDATA: r_next.rdata = {16'h0000, r_reg.req_wdata};
				dee_pkg::OFS_STATUS: r_next.rdata = {29'h0000_0000, r_reg.rd_valid, r_reg.irq,
					r_reg.req_pend};
				dee_pkg::OFS_RDATA: r_next.rdata = {16'h0000, r_reg.rd_data};
				default: r_next.rresp = dee_pkg::RESP_SLVERR;
			endcase
		end
		// events set after software clears, so a same-cycle event wins
		if (LINK.rsp_valid) begin
			r_next.rd_data = LINK.rsp_data;
			r_next.rd_valid = 1'b1;
		end
		if (LINK.done_flag) begin
			r_next.irq = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign S_AXI_AWREADY_O = !r_reg.aw_got && !r_reg.bvalid;
	assign S_AXI_WREADY_O = !r_reg.w_got && !r_reg.bvalid;
	assign S_AXI_BVALID_O = r_reg.bvalid;
	assign S_AXI_BRESP_O = r_reg.bresp;
	assign S_AXI_ARREADY_O = !r_reg.rvalid;
	assign S_AXI_RVALID_O = r_reg.rvalid;
	assign S_AXI_RDATA_O = r_reg.rdata;
	assign S_AXI_RRESP_O = r_reg.rresp;
	// one link request per command write
	assign LINK.req_valid = r_reg.req_pend;
	assign LINK.req_kind = r_reg.req_kind;
	assign LINK.req_addr = r_reg.req_addr;
	assign LINK.req_wdata = r_reg.req_wdata;
endmodule : dee_cpu_ctrl

// >>> dv/dee_link_assertions.sv
`timescale 1ns/100ps
module dee_link_assertions (
	input wire logic CLK_SYS_I,
	input wire logic NRST_I,
	input wire logic req_valid,
	input wire dee_pkg::dee_req_e req_kind,
	input wire logic [23:0] req_addr,
	input wire logic [15:0] req_wdata,
	input wire logic rsp_valid,
	input wire logic [15:0] rsp_data,
	input wire logic done_flag,
	input wire logic BUSY_O
);
	logic got_first_reg;
	logic open_reg;
	logic legal;
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!NRST_I);
	// follows the key pair across link requests
	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			got_first_reg <= 1'b0;
			open_reg <= 1'b0;
		end else if (req_valid) begin
			got_first_reg <= req_kind == dee_pkg::REQ_KEY_WR && req_wdata == dee_pkg::KEY_FIRST;
			open_reg <= got_first_reg && req_kind == dee_pkg::REQ_KEY_WR &&
				req_wdata == dee_pkg::KEY_SECOND;
		end
	end
	assign legal = req_wdata[6] ? (req_wdata[5:0] inside {6'h18, 6'h19, 6'h1A} ||
		req_wdata[5:2] == 4'h4) : req_wdata[5:2] == 4'h1;
	sequence s_read_req;
		req_valid && !(req_kind inside {dee_pkg::REQ_KEY_WR, dee_pkg::REQ_CTL_WR,
			dee_pkg::REQ_TBL_WR_LO});
	endsequence
	sequence s_start_req;
		req_valid && req_kind == dee_pkg::REQ_CTL_WR && req_wdata[15] && req_wdata[14];
	endsequence
	a_read_answers: assert property (s_read_req |=> rsp_valid)
		else $error("read request got no answer");
	a_no_stray_answer: assert property (rsp_valid |-> $past(req_valid) && !($past(req_kind) inside
		{dee_pkg::REQ_KEY_WR, dee_pkg::REQ_CTL_WR, dee_pkg::REQ_TBL_WR_LO}))
		else $error("answer without read request");
	a_key_reads_zero: assert property (req_valid && req_kind == dee_pkg::REQ_KEY_RD |=>
		rsp_data == 16'h0000) else $error("key register read back nonzero");
	a_high_reads_zero: assert property (req_valid && req_kind == dee_pkg::REQ_TBL_RD_HI |=>
		rsp_data == 16'h0000) else $error("high table read nonzero");
	a_start_needs_key: assert property ($rose(BUSY_O) |-> $past(req_valid && open_reg &&
		req_kind == dee_pkg::REQ_CTL_WR && req_wdata[15]))
		else $error("operation began without unlock");
	a_start_begins: assert property (s_start_req ##0 (open_reg && legal && !BUSY_O) |=> BUSY_O)
		else $error("unlocked start ignored");
	a_busy_min: assert property ($rose(BUSY_O) |-> BUSY_O[*4])
		else $error("operation ended too early");
	a_busy_ends: assert property ($rose(BUSY_O) |-> ##[1:120] !BUSY_O)
		else $error("start bit never cleared");
	a_done_after_busy: assert property (done_flag |-> $past(BUSY_O) || $past(BUSY_O, 2))
		else $error("done without operation");
	a_done_single: assert property (done_flag |=> !done_flag)
		else $error("done flag longer than one cycle");
endmodule : dee_link_assertions

// >>> dv/data_eeprom_controller_tb_top.sv
`timescale 1ns/100ps
module data_eeprom_controller_tb_top;
	logic CLK_SYS_I = 1'b0;
	logic NRST_I = 1'b0;
	logic RESET_ABORT_I = 1'b0;
	logic BUSY_O;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	int n_errors = 0;
	int compares = 0;
	int busy_cnt = 0;
	int busy_base = 0;
	dee_link_if dee_link_if_inst ();
	dee_device #(.ERASE_CYC(12'h028), .PROG_CYC(12'h01E)) dee_device_inst (.CLK_SYS_I(CLK_SYS_I),
		.NRST_I(NRST_I), .LINK(dee_link_if_inst), .RESET_ABORT_I(RESET_ABORT_I), .BUSY_O(BUSY_O));
	dee_cpu_ctrl dee_cpu_ctrl_inst (.CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I), .LINK(dee_link_if_inst),
		.S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
		.S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid),
		.S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
		.S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
		.S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
		.S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready));
	dee_link_assertions dee_link_assertions_inst (.CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I),
		.req_valid(dee_link_if_inst.req_valid), .req_kind(dee_link_if_inst.req_kind),
		.req_addr(dee_link_if_inst.req_addr), .req_wdata(dee_link_if_inst.req_wdata),
		.rsp_valid(dee_link_if_inst.rsp_valid), .rsp_data(dee_link_if_inst.rsp_data),
		.done_flag(dee_link_if_inst.done_flag), .BUSY_O(BUSY_O));
	always #25 CLK_SYS_I = ~CLK_SYS_I;
	always @(posedge CLK_SYS_I) if (BUSY_O === 1'b1) busy_cnt <= busy_cnt + 1;
	task automatic tally_and_finish();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// bus tasks start and end just after a rising edge; handshakes sampled mid-cycle
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int i;
		logic aw, w, b, ah, wh, bh;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		b = 1'b1;
		for (i = 0; i < 60 && b; i++) begin
			@(negedge CLK_SYS_I);
			ah = aw && awready;
			wh = w && wready;
			bh = b && bvalid;
			if (bh) chk(bresp, er);
			@(posedge CLK_SYS_I);
			if (ah) begin awvalid <= 1'b0; aw = 1'b0; end
			if (wh) begin wvalid <= 1'b0; w = 1'b0; end
			if (bh) begin bready <= 1'b0; b = 1'b0; end
		end
		if (b) begin n_errors++; tally_and_finish(); end
		// idle edge: no handshake signal is assigned twice in one step
		@(posedge CLK_SYS_I);
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int i;
		logic ar, rr, ah, rh;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		ar = 1'b1;
		rr = 1'b1;
		for (i = 0; i < 60 && rr; i++) begin
			@(negedge CLK_SYS_I);
			ah = ar && arready;
			rh = rr && rvalid;
			if (rh) begin d = rdata; r = rresp; end
			@(posedge CLK_SYS_I);
			if (ah) begin arvalid <= 1'b0; ar = 1'b0; end
			if (rh) begin rready <= 1'b0; rr = 1'b0; end
		end
		if (rr) begin n_errors++; tally_and_finish(); end
		@(posedge CLK_SYS_I);
	endtask : axi_rd
	task automatic link(input dee_pkg::dee_req_e k, input logic [23:0] a, input logic [15:0] d);
		axi_wr(dee_pkg::OFS_ADDR, {8'h00, a}, dee_pkg::RESP_OKAY);
		axi_wr(dee_pkg::OFS_WDATA, {16'h0000, d}, dee_pkg::RESP_OKAY);
		axi_wr(dee_pkg::OFS_CMD, {29'h0000_0000, k}, dee_pkg::RESP_OKAY);
	endtask : link
	task automatic rd_link(input dee_pkg::dee_req_e k, input logic [23:0] a, input logic [15:0] e);
		logic [31:0] d;
		logic [1:0] r;
		link(k, a, 16'h0000);
		axi_rd(dee_pkg::OFS_RDATA, d, r);
		chk(d, {16'h0000, e});
		chk(r, dee_pkg::RESP_OKAY);
	endtask : rd_link
	task automatic go(input logic [15:0] ctl);
		busy_base = busy_cnt;
		link(dee_pkg::REQ_KEY_WR, 24'h00_0000, 16'h0055);
		link(dee_pkg::REQ_KEY_WR, 24'h00_0000, 16'h00AA);
		link(dee_pkg::REQ_CTL_WR, 24'h00_0000, ctl);
	endtask : go
	task automatic wait_done();
		logic [31:0] d;
		logic [1:0] r;
		int i;
		d = 32'h0000_0000;
		for (i = 0; i < 40 && d[1] !== 1'b1; i++) axi_rd(dee_pkg::OFS_STATUS, d, r);
		chk(d[1], 32'h0000_0001);
		if (d[1] !== 1'b1) tally_and_finish();
		axi_wr(dee_pkg::OFS_STATUS, 32'h0000_0006, dee_pkg::RESP_OKAY);
	endtask : wait_done
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(dee_pkg::OFS_STATUS, d, r);
		chk(d, 32'h0000_0000);
		axi_rd(8'h20, d, r);
		chk(d, 32'h0000_0000);
		chk(r, dee_pkg::RESP_SLVERR);
		axi_wr(8'h20, 32'h0000_0001, dee_pkg::RESP_SLVERR);
		rd_link(dee_pkg::REQ_CTL_RD, 24'h00_0000, 16'h0000);
	endtask : t_regs
	task automatic t_erase();
		logic [5:0] cmd [3] = '{dee_pkg::CMD_ERASE1, dee_pkg::CMD_ERASE4, dee_pkg::CMD_ERASE8};
		int n [3] = '{1, 4, 8};
		logic [23:0] a;
		for (int j = 0; j < 3; j++) begin
			a = 24'h7F_FE00 + 24'(32 * (j + 1));
			link(dee_pkg::REQ_TBL_WR_LO, a | 24'(j == 0), 16'h0000);
			go({10'h301, cmd[j]});
			wait_done();
			rd_link(dee_pkg::REQ_TBL_RD_LO, a + 24'(2 * n[j] - 2), 16'hFFFF);
			rd_link(dee_pkg::REQ_TBL_RD_LO, a + 24'(2 * n[j]), 16'h0000);
			rd_link(dee_pkg::REQ_CTL_RD, 24'h00_0000, {10'h001, cmd[j]});
		end
	endtask : t_erase
	task automatic t_prog();
		link(dee_pkg::REQ_TBL_WR_LO, 24'h7F_FE10, 16'h1234);
		go(16'hC004);
		wait_done();
		chk((busy_cnt - busy_base) > 69, 32'h0000_0001);
		rd_link(dee_pkg::REQ_TBL_RD_LO, 24'h7F_FE10, 16'h1234);
		rd_link(dee_pkg::REQ_PSV_RD, 24'h7F_FE10, 16'h1234);
		rd_link(dee_pkg::REQ_TBL_RD_HI, 24'h7F_FE10, 16'h0000);
		rd_link(dee_pkg::REQ_KEY_RD, 24'h00_0000, 16'h0000);
		link(dee_pkg::REQ_TBL_WR_LO, 24'h7F_FE20, 16'h00FF);
		go(16'hD007);
		wait_done();
		chk((busy_cnt - busy_base) < 40, 32'h0000_0001);
		rd_link(dee_pkg::REQ_TBL_RD_LO, 24'h7F_FE20, 16'h00FF);
	endtask : t_prog
	task automatic t_lock();
		for (int c = 0; c < 3; c++) begin
			busy_base = busy_cnt;
			link(dee_pkg::REQ_KEY_WR, 24'h00_0000, c == 0 ? 16'h00AA : 16'h0055);
			link(dee_pkg::REQ_KEY_WR, 24'h00_0000, c == 0 ? 16'h0055 : 16'h00AA);
			if (c == 1) link(dee_pkg::REQ_CTL_RD, 24'h00_0000, 16'h0000);
			link(dee_pkg::REQ_CTL_WR, 24'h00_0000, c == 2 ? 16'h8058 : 16'hC058);
			repeat (3) @(posedge CLK_SYS_I);
			chk(busy_cnt - busy_base, 32'h0000_0000);
		end
	endtask : t_lock
	task automatic t_abort();
		logic [31:0] d;
		logic [1:0] r;
		link(dee_pkg::REQ_TBL_WR_LO, 24'h7F_FE30, 16'h5555);
		go(16'hC004);
		rd_link(dee_pkg::REQ_CTL_RD, 24'h00_0000, 16'hC004);
		RESET_ABORT_I <= 1'b1;
		repeat (4) @(posedge CLK_SYS_I);
		RESET_ABORT_I <= 1'b0;
		repeat (4) @(posedge CLK_SYS_I);
		@(negedge CLK_SYS_I);
		chk(BUSY_O, 32'h0000_0000);
		@(posedge CLK_SYS_I);
		rd_link(dee_pkg::REQ_CTL_RD, 24'h00_0000, 16'h2004);
		axi_rd(dee_pkg::OFS_STATUS, d, r);
		chk(d[1], 32'h0000_0000);
		go(16'hC004);
		wait_done();
		rd_link(dee_pkg::REQ_CTL_RD, 24'h00_0000, 16'h0004);
		rd_link(dee_pkg::REQ_TBL_RD_LO, 24'h7F_FE30, 16'h5555);
	endtask : t_abort
	task automatic t_bulk();
		go(16'hC053);
		wait_done();
		rd_link(dee_pkg::REQ_TBL_RD_LO, 24'h7F_FE10, 16'hFFFF);
		rd_link(dee_pkg::REQ_TBL_RD_LO, 24'h7F_FFFE, 16'hFFFF);
	endtask : t_bulk
	initial begin
		repeat (6) @(posedge CLK_SYS_I);
		NRST_I <= 1'b1;
		@(posedge CLK_SYS_I);
		t_regs();
		t_erase();
		t_prog();
		t_lock();
		t_abort();
		t_bulk();
		tally_and_finish();
	end
endmodule : data_eeprom_controller_tb_top
